// ---- gas_pkg.sv ----
package gas_pkg;

  // ==========================================================
  // Pin count and pin positions
  localparam int NUM_PINS = 5;
  localparam int PIN_RX = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_TX = 2;
  localparam int PIN_SEL0 = 3;
  localparam int PIN_SEL1 = 4;

  // ==========================================================
  // Serial clock timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 160;
  localparam int SCK_HALF_INT = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_INT);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================================
  // Strap capture
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] LANE_BASE = 3'h1;

  // ==========================================================
  // Reset values
  localparam logic [4:0] PAD_OUT_RST = 5'h00;
  localparam logic [4:0] PAD_OE_RST = 5'h00;
  localparam logic [2:0] LANE_RST = 3'h1;

  // ==========================================================
  // Modes and states
  typedef enum {
    GAS_MODE_IN, GAS_MODE_OUT, GAS_MODE_BIDIR, GAS_MODE_OD
  } gas_mode_e;
  typedef enum {GAS_P4_GPIO, GAS_P4_GLASSES, GAS_P4_SELECT} gas_p4_e;
  typedef enum {GAS_IDLE, GAS_SHIFT, GAS_TAIL} gas_xfer_e;

endpackage

// ---- gas_spi_if.sv ----
`timescale 1ns/1ps
interface gas_spi_if;
  logic start;
  logic [7:0] tx_byte;
  logic target;
  logic miso;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic sck;
  logic mosi;
  logic cs0_n;
  logic cs1_n;

  modport ctl (
    output start, tx_byte, target, miso,
    input busy, done, rx_byte, sck, mosi, cs0_n, cs1_n
  );
  modport eng (
    input start, tx_byte, target, miso,
    output busy, done, rx_byte, sck, mosi, cs0_n, cs1_n
  );
endinterface

// ---- gas_spi_engine.sv ----
`timescale 1ns/1ps
module gas_spi_engine (
  input logic clk,
  input logic rst,
  input logic ce,
  gas_spi_if.eng bus
);
  import gas_pkg::*;

  gas_xfer_e state_r;
  logic [3:0] div_r;
  logic [2:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [7:0] rx_out_r;
  logic sck_r;
  logic cs0_r;
  logic cs1_r;
  logic done_r;
  logic tick;

  // ==========================================================
  // Half period timer
  assign tick = (state_r != GAS_IDLE) && (div_r == SCK_HALF_CYC - 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 4'h0;
    end else if (ce) begin
      if (state_r == GAS_IDLE || tick) begin
        div_r <= 4'h0;
      end else begin
        div_r <= div_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // Sequencer and selects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= GAS_IDLE;
      bit_r <= 3'h0;
      sck_r <= 1'b0;
      cs0_r <= 1'b1;
      cs1_r <= 1'b1;
      done_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      unique case (state_r)
        GAS_IDLE: begin
          if (bus.start) begin
            state_r <= GAS_SHIFT;
            bit_r <= 3'h0;
            sck_r <= 1'b0;
            cs0_r <= bus.target; // R5
            cs1_r <= !bus.target; // R4
          end
        end
        GAS_SHIFT: begin
          if (tick) begin
            sck_r <= !sck_r; // R7
            if (sck_r) begin
              if (bit_r == LAST_BIT) begin
                state_r <= GAS_TAIL;
              end else begin
                bit_r <= bit_r + 3'h1;
              end
            end
          end
        end
        GAS_TAIL: begin
          if (tick) begin
            cs0_r <= 1'b1;
            cs1_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= GAS_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Data shifters, MSB first, mode 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rx_out_r <= 8'h00;
    end else if (ce) begin
      if (state_r == GAS_IDLE && bus.start) begin
        tx_r <= bus.tx_byte;
      end else if (state_r == GAS_SHIFT && tick) begin
        if (!sck_r) begin
          rx_r <= {rx_r[6:0], bus.miso}; // R8
        end else begin
          tx_r <= {tx_r[6:0], 1'b0}; // R6
        end
      end else if (state_r == GAS_TAIL && tick) begin
        rx_out_r <= rx_r;
      end
    end
  end

  assign bus.busy = (state_r != GAS_IDLE);
  assign bus.done = done_r;
  assign bus.rx_byte = rx_out_r;
  assign bus.sck = sck_r;
  assign bus.mosi = tx_r[7];
  assign bus.cs0_n = cs0_r;
  assign bus.cs1_n = cs1_r;

  // ==========================================================
  // Checks
  property p_sel_busy;
    @(posedge clk) disable iff (rst)
    (!cs0_r || !cs1_r) |-> (state_r != GAS_IDLE);
  endproperty
  a_sel_busy: assert property (p_sel_busy) // R5
    else $error("Select low while idle");

  property p_one_sel;
    @(posedge clk) disable iff (rst)
    !(!cs0_r && !cs1_r);
  endproperty
  a_one_sel: assert property (p_one_sel) // R4
    else $error("Both selects low");

  property p_sck_idle;
    @(posedge clk) disable iff (rst)
    (state_r != GAS_SHIFT) |-> !sck_r;
  endproperty
  a_sck_idle: assert property (p_sck_idle) // R7
    else $error("Serial clock high outside shifting");

  c_xfer_done: cover property (@(posedge clk) disable iff (rst) done_r);
endmodule

// ---- gas_gpio_port.sv ----
`timescale 1ns/1ps
// Behaviour
// [R1] Each pin is set to input, output, bidirectional or open-drain; open-drain only pulls low.
// [R2] A per-pin selection routes either the plain GPIO path or the alternate function.
// [R3] Pin 4 in glasses role is high for the left shutter and low for the right.
// [R4] Pin 4 in select role is the second active-low chip select, low only while that slave is addressed.
// [R5] Pin 3 is the primary active-low chip select, low only during transfers to the power chip.
// [R6] Pin 2 in serial role carries the master transmit data.
// [R7] Pin 1 in serial role carries the master serial clock.
// [R8] Pin 0 in serial role is the master receive data input.
// [R9] Pins 2 and 1 are sampled at boot as a strap that sets the display lane count.
// [R10] Strap decode: pin 2 high bit, pin 1 low bit, 00 to 11 give one to four lanes.
// [R11] After the strap sample pins 2 and 1 drive serial data and clock again.
// [R12] An unused pin can be forced to a driven logic zero so it never floats.
// [R13] The strap is latched once after reset release and held until the next reset.
module gas_gpio_port (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic [4:0] pad_in,
  output logic [4:0] pad_out,
  output logic [4:0] pad_oe,
  input gas_pkg::gas_mode_e gpio_mode [gas_pkg::NUM_PINS],
  input logic [4:0] gpio_out,
  input logic [4:0] gpio_dir,
  input logic [4:0] gpio_unused,
  output logic [4:0] gpio_in,
  input logic [3:0] serial_sel,
  input gas_pkg::gas_p4_e pin4_func,
  input logic left_eye,
  input logic xfer_start,
  input logic [7:0] xfer_byte,
  input logic xfer_target,
  output logic xfer_busy,
  output logic xfer_done,
  output logic [7:0] xfer_rx,
  output logic [2:0] lane_count,
  output logic strap_done
);
  import gas_pkg::*;

  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [1:0] settle_r;
  logic strap_done_r;
  logic [1:0] strap_code_r;
  logic [2:0] lane_r;
  logic [4:0] gout;
  logic [4:0] goe;
  logic [4:0] pad_out_nxt;
  logic [4:0] pad_oe_nxt;
  logic [4:0] pad_out_r;
  logic [4:0] pad_oe_r;

  gas_spi_if spi ();

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else if (ce) begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
    end
  end

  assign gpio_in = sync2_r;

  // ==========================================================
  // Lane strap capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      strap_code_r <= 2'h0;
      lane_r <= LANE_RST;
    end else if (ce && !strap_done_r) begin
      if (settle_r == STRAP_SETTLE) begin
        strap_done_r <= 1'b1; // R13
        strap_code_r <= sync2_r[PIN_TX:PIN_SCK]; // R9
        lane_r <= {1'b0, sync2_r[PIN_TX:PIN_SCK]} + LANE_BASE; // R10
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

  assign strap_done = strap_done_r;
  assign lane_count = lane_r;

  // ==========================================================
  // Serial master
  assign spi.start = xfer_start;
  assign spi.tx_byte = xfer_byte;
  assign spi.target = xfer_target;
  assign spi.miso = sync2_r[PIN_RX]; // R8
  assign xfer_busy = spi.busy;
  assign xfer_done = spi.done;
  assign xfer_rx = spi.rx_byte;

  gas_spi_engine u_engine (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bus(spi)
  );

  // ==========================================================
  // Plain GPIO path
  always_comb begin
    gout = 5'h00;
    goe = 5'h00;
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (gpio_mode[i])
        GAS_MODE_IN: begin
          gout[i] = 1'b0;
          goe[i] = 1'b0;
        end
        GAS_MODE_OUT: begin
          gout[i] = gpio_out[i];
          goe[i] = 1'b1;
        end
        GAS_MODE_BIDIR: begin
          gout[i] = gpio_out[i];
          goe[i] = gpio_dir[i];
        end
        GAS_MODE_OD: begin
          gout[i] = 1'b0; // R1
          goe[i] = !gpio_out[i]; // R1
        end
      endcase
      if (gpio_unused[i]) begin
        gout[i] = 1'b0; // R12
        goe[i] = 1'b1; // R12
      end
    end
  end

  // ==========================================================
  // Alternate function mux
  always_comb begin
    pad_out_nxt = gout;
    pad_oe_nxt = goe;
    if (serial_sel[PIN_RX]) begin // R2
      pad_out_nxt[PIN_RX] = 1'b0;
      pad_oe_nxt[PIN_RX] = 1'b0; // R8
    end
    if (serial_sel[PIN_SCK]) begin // R2
      pad_out_nxt[PIN_SCK] = spi.sck; // R7
      pad_oe_nxt[PIN_SCK] = 1'b1; // R11
    end
    if (serial_sel[PIN_TX]) begin // R2
      pad_out_nxt[PIN_TX] = spi.mosi; // R6
      pad_oe_nxt[PIN_TX] = 1'b1; // R11
    end
    if (serial_sel[PIN_SEL0]) begin // R2
      pad_out_nxt[PIN_SEL0] = spi.cs0_n; // R5
      pad_oe_nxt[PIN_SEL0] = 1'b1;
    end
    unique case (pin4_func) // R2
      GAS_P4_GPIO: begin
      end
      GAS_P4_GLASSES: begin
        pad_out_nxt[PIN_SEL1] = left_eye; // R3
        pad_oe_nxt[PIN_SEL1] = 1'b1;
      end
      GAS_P4_SELECT: begin
        pad_out_nxt[PIN_SEL1] = spi.cs1_n; // R4
        pad_oe_nxt[PIN_SEL1] = 1'b1;
      end
    endcase
    if (!strap_done_r) begin
      pad_out_nxt[PIN_TX:PIN_SCK] = 2'h0; // R9
      pad_oe_nxt[PIN_TX:PIN_SCK] = 2'h0; // R9
    end
  end

  // ==========================================================
  // Pad registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_r <= PAD_OUT_RST;
      pad_oe_r <= PAD_OE_RST;
    end else if (ce) begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;

  // ==========================================================
  // Checks
  property p_od_low;
    @(posedge clk) disable iff (rst)
    (ce && gpio_mode[PIN_SEL0] == GAS_MODE_OD && !serial_sel[PIN_SEL0]
      && !gpio_unused[PIN_SEL0])
      |=> !pad_out[PIN_SEL0] && (pad_oe[PIN_SEL0] == !$past(gpio_out[3]));
  endproperty
  a_od_low: assert property (p_od_low) // R1
    else $error("Open-drain pin drove high or wrong release");

  property p_glasses;
    @(posedge clk) disable iff (rst)
    (ce && pin4_func == GAS_P4_GLASSES)
      |=> pad_oe[PIN_SEL1] && pad_out[PIN_SEL1] == $past(left_eye);
  endproperty
  a_glasses: assert property (p_glasses) // R3
    else $error("Glasses output does not follow shutter side");

  property p_sel1;
    @(posedge clk) disable iff (rst)
    (ce && pin4_func == GAS_P4_SELECT)
      |=> pad_oe[PIN_SEL1] && pad_out[PIN_SEL1] == $past(spi.cs1_n);
  endproperty
  a_sel1: assert property (p_sel1) // R4
    else $error("Second select not routed to pin 4");

  property p_sel0;
    @(posedge clk) disable iff (rst)
    (ce && serial_sel[PIN_SEL0] && !xfer_busy)
      |=> pad_oe[PIN_SEL0] && pad_out[PIN_SEL0];
  endproperty
  a_sel0: assert property (p_sel0) // R5
    else $error("Primary select low outside a transfer");

  property p_tx;
    @(posedge clk) disable iff (rst)
    (ce && serial_sel[PIN_TX] && strap_done)
      |=> pad_oe[PIN_TX] && pad_out[PIN_TX] == $past(spi.mosi);
  endproperty
  a_tx: assert property (p_tx) // R6
    else $error("Transmit data not on pin 2");

  property p_sck;
    @(posedge clk) disable iff (rst)
    (ce && serial_sel[PIN_SCK] && strap_done)
      |=> pad_oe[PIN_SCK] && pad_out[PIN_SCK] == $past(spi.sck);
  endproperty
  a_sck: assert property (p_sck) // R7
    else $error("Serial clock not on pin 1");

  property p_rx;
    @(posedge clk) disable iff (rst)
    (ce && serial_sel[PIN_RX]) |=> !pad_oe[PIN_RX];
  endproperty
  a_rx: assert property (p_rx) // R8
    else $error("Receive pin driven");

  property p_strap_float;
    @(posedge clk) disable iff (rst)
    (ce && !strap_done) |=> pad_oe[PIN_TX:PIN_SCK] == 2'h0;
  endproperty
  a_strap_float: assert property (p_strap_float) // R9
    else $error("Strap pins driven before sample");

  property p_lane_decode;
    @(posedge clk) disable iff (rst)
    strap_done |-> lane_count == {1'b0, strap_code_r} + LANE_BASE;
  endproperty
  a_lane_decode: assert property (p_lane_decode) // R10
    else $error("Lane count decode wrong");

  property p_strap_hold;
    @(posedge clk) disable iff (rst)
    strap_done |=> strap_done && $stable(lane_count)
      && $stable(strap_code_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // R13
    else $error("Strap changed after capture");

  property p_strap_time;
    @(posedge clk) disable iff (rst)
    $rose(strap_done) |-> $past(sync2_r[PIN_TX:PIN_SCK]) == strap_code_r;
  endproperty
  a_strap_time: assert property (p_strap_time) // R9
    else $error("Strap code not from sampled pins");

  property p_unused;
    @(posedge clk) disable iff (rst)
    (ce && gpio_unused[PIN_RX] && !serial_sel[PIN_RX])
      |=> pad_oe[PIN_RX] && !pad_out[PIN_RX];
  endproperty
  a_unused: assert property (p_unused) // R12
    else $error("Unused pin not driven low");

  c_glasses: cover property (@(posedge clk) disable iff (rst)
    pin4_func == GAS_P4_GLASSES && pad_out[PIN_SEL1]);
  c_four_lanes: cover property (@(posedge clk) disable iff (rst)
    strap_done && lane_count == 3'h4);
  c_aux_xfer: cover property (@(posedge clk) disable iff (rst)
    pin4_func == GAS_P4_SELECT && !pad_out[PIN_SEL1]);
endmodule

// ---- gas_pmic_model.sv ----
`timescale 1ns/1ps
module gas_pmic_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh;

  // ==========================================================
  // Mode 0 slave: first bit ready at select, shift on falling clock
  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
  end
  always @(negedge cs_n) begin
    sh = reply;
    miso = reply[7];
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      got = {got[6:0], mosi};
    end
  end
  always @(negedge sck) begin
    if (!cs_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
  // Released line shows the inverse of its last value
  always @(posedge cs_n) begin
    miso = ~miso;
  end
endmodule

// ---- gpio_alt_function_strap_port_tb.sv ----
`timescale 1ns/1ps
module gpio_alt_function_strap_port_tb;
  import gas_pkg::*;
  logic clk, rst, ce, left_eye, xfer_start, xfer_target;
  logic [4:0] pad_in, pad_out, pad_oe, gpio_out, gpio_dir, gpio_unused;
  logic [4:0] gpio_in, ext_val, pin_w, eoe, eout;
  logic [3:0] serial_sel;
  logic [7:0] xfer_byte, xfer_rx, reply, got;
  logic [2:0] lane_count;
  logic xfer_busy, xfer_done, strap_done, miso, sel3;
  gas_mode_e gpio_mode [NUM_PINS];
  gas_p4_e pin4_func;
  logic [31:0] seed;
  int fails, checks;

  // ==========================================================
  // Pin wires: design drive or far-side level
  assign sel3 = pad_oe[3] ? pad_out[3] : ext_val[3];
  assign pin_w = (pad_oe & pad_out) |
    (~pad_oe & {ext_val[4:1], sel3 ? ext_val[0] : miso});
  assign pad_in = pin_w;

  gas_gpio_port u_gas_gpio_port (.clk(clk), .rst(rst), .ce(ce),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .gpio_mode(gpio_mode), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
    .gpio_unused(gpio_unused), .gpio_in(gpio_in),
    .serial_sel(serial_sel), .pin4_func(pin4_func), .left_eye(left_eye),
    .xfer_start(xfer_start), .xfer_byte(xfer_byte),
    .xfer_target(xfer_target), .xfer_busy(xfer_busy),
    .xfer_done(xfer_done), .xfer_rx(xfer_rx), .lane_count(lane_count),
    .strap_done(strap_done));
  gas_pmic_model u_gas_pmic_model (.sck(pin_w[PIN_SCK]),
    .cs_n(pin_w[PIN_SEL0]), .mosi(pin_w[PIN_TX]), .reply(reply),
    .miso(miso), .got(got));

  always #5 clk = ~clk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [9:0] exp_pad(gas_mode_e m, logic [4:0] o,
                                         logic [4:0] d, logic [4:0] u);
    logic [4:0] oe, v;
    oe = (m == GAS_MODE_OUT) ? 5'h1f : (m == GAS_MODE_BIDIR) ? d :
         (m == GAS_MODE_OD) ? ~o : 5'h00;
    v = (m == GAS_MODE_OD) ? 5'h00 : o;
    return {oe | u, v & ~u};
  endfunction
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic report(logic [7:0] g, logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(logic [4:0] g, logic [4:0] e);
    report({3'h0, g}, {3'h0, e});
  endtask
  task automatic chk_byte(logic [7:0] g, logic [7:0] e);
    report(g, e);
  endtask
  task automatic chk_lane(logic [2:0] g, logic [2:0] e);
    report({5'h00, g}, {5'h00, e});
  endtask
  task automatic chk_bit(logic g, logic e);
    report({7'h00, g}, {7'h00, e});
  endtask
  task automatic wait_flag(input int which);
    int n;
    n = 0;
    while ((which == 0 ? strap_done : xfer_done) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) begin
      fails++;
      summarize();
    end
  endtask
  task automatic do_reset(logic [1:0] s);
    ext_val = {2'b11, s, 1'b0};
    rst = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_pin(pad_oe & 5'h06, 5'h00);
    chk_bit(strap_done, 1'b0);
    wait_flag(0);
    chk_lane(lane_count, {1'b0, s} + 3'h1);
    ext_val[2:1] = ~s;
    repeat (10) @(negedge clk);
    chk_lane(lane_count, {1'b0, s} + 3'h1);
    chk_pin(pad_oe & 5'h06, 5'h06);
    chk_pin(pin_w & 5'h02, 5'h00);
  endtask
  task automatic xfer(logic tgt);
    logic [7:0] b;
    b = 8'(rnd());
    reply = 8'(rnd());
    xfer_byte = b;
    xfer_target = tgt;
    xfer_start = 1'b1;
    @(negedge clk);
    xfer_start = 1'b0;
    repeat (20) @(negedge clk);
    chk_pin(pin_w & 5'h18, tgt ? 5'h08 : 5'h10);
    chk_bit(xfer_busy, 1'b1);
    wait_flag(1);
    chk_byte(xfer_rx, tgt ? {8{ext_val[0]}} : reply);
    if (!tgt) begin
      chk_byte(got, b);
    end
    @(negedge clk);
    chk_bit(xfer_done, 1'b0);
    chk_bit(xfer_busy, 1'b0);
    @(negedge clk);
    chk_pin(pin_w & 5'h18, 5'h18);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    ce = 1'b1;
    seed = 32'd72645;
    fails = 0;
    checks = 0;
    left_eye = 1'b0;
    xfer_start = 1'b0;
    xfer_byte = 8'h00;
    xfer_target = 1'b0;
    reply = 8'h00;
    gpio_out = 5'h00;
    gpio_dir = 5'h00;
    gpio_unused = 5'h00;
    serial_sel = 4'hf;
    pin4_func = GAS_P4_SELECT;
    for (int i = 0; i < NUM_PINS; i++) gpio_mode[i] = GAS_MODE_IN;
    for (int s = 0; s < 4; s++) do_reset(2'(s));
    ext_val = 5'h18;
    for (int k = 0; k < 6; k++) xfer(k[0]);
    serial_sel = 4'h0;
    pin4_func = GAS_P4_GPIO;
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < NUM_PINS; i++) gpio_mode[i] = gas_mode_e'(k % 4);
      gpio_out = 5'(rnd());
      gpio_dir = 5'(rnd());
      gpio_unused = (k > 11) ? 5'h1f : 5'(rnd() & rnd());
      ext_val = 5'(rnd());
      {eoe, eout} = exp_pad(gas_mode_e'(k % 4), gpio_out, gpio_dir,
                            gpio_unused);
      repeat (4) @(negedge clk);
      chk_pin(pad_oe, eoe);
      chk_pin(pad_out & eoe, eout & eoe);
      chk_pin(gpio_in, pin_w);
    end
    pin4_func = GAS_P4_GLASSES;
    for (int k = 0; k < 8; k++) begin
      left_eye = 1'(rnd());
      repeat (2) @(negedge clk);
      chk_pin(pad_oe & 5'h10, 5'h10);
      chk_pin(pad_out & 5'h10, {left_eye, 4'h0});
    end
    // Clock enable low freezes the pad registers
    ce = 1'b0;
    left_eye = ~left_eye;
    repeat (3) @(negedge clk);
    chk_pin(pad_out & 5'h10, {~left_eye, 4'h0});
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk_pin(pad_out & 5'h10, {left_eye, 4'h0});
    summarize();
  end
endmodule
